// ### rtl/t1pwm_core.sv
// Function
// - in PWM mode the counter runs $00 up to top, then restarts
// - counter wrapping from $FF, or from top in PWM, to $00 sets overflow flag after delay
// - interrupt requested when flag, its enable and global enable are set
// - PWM mode 00 leaves both outputs of a channel disconnected
// - mode 01: true clears on match, sets at $01; inverse opposite at $00
// - mode 10: true clears on match, sets at $01; inverse disconnected
// - mode 11: true sets on match, clears at $01; inverse disconnected
// - non-overlap gap: inverse clears at $00, true sets at $01, one count both low
// - PWM compare writes go to holding register, loaded at top
// - compare reads return the holding register, the last write
// - in PWM, compare at $00 or top gives a constant output level
// - PWM period is counter clock period times top plus one
// - clear-on-top bit resets counter after top match, else counts on
// - either channel's PWM enable bit resets counter after top match
// - outside PWM, mode bits give off, toggle, clear or set on match
// - outside PWM the inverted output of channel A is never driven
// - clock select 0 stops, 1..15 divide base clock by 1..16384
// - fast clock select picks the fast clock tick as prescaler base
// - compare match A sets its flag after a synchronisation delay
`include "t1pwm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module t1pwm_core (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // clocking and interrupt context
   input wire logic fastClkTick,
   input wire logic pllLock,
   input wire logic globalIntEn,
   // outputs
   output t1pwm_pkg::t1pwm_pins_t pins,
   output t1pwm_pkg::t1pwm_irq_t irq
);

   t1pwm_pkg::t1pwm_state_t st;
   t1pwm_pkg::t1pwm_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // one channel: returns {true, trueEn, inv, invEn}
   function automatic t1pwm_pkg::t1pwm_pair_t chanNext(
      input logic pwm,
      input logic [1:0] mode,
      input logic [7:0] cmp,
      input logic [7:0] top,
      input logic [7:0] cnt,
      input logic newCnt,
      input logic force_,
      input t1pwm_pkg::t1pwm_pair_t cur
   );
      t1pwm_pkg::t1pwm_pair_t p;
      logic matchLvl;
      logic hit;
      p = cur;
      matchLvl = (mode == `T1PWM_MODE_SET);
      hit = newCnt && (cnt == cmp);
      if (pwm) begin
         p.trueEn = (mode != `T1PWM_MODE_OFF);
         p.invEn = (mode == `T1PWM_MODE_TOGGLE);
         if (cmp == `T1PWM_CNT_ZERO) begin
            p.trueOut = matchLvl;
         end else if (cmp == top) begin
            p.trueOut = ~matchLvl;
         end else if (hit) begin
            p.trueOut = matchLvl;
         end else if (newCnt && cnt == `T1PWM_CNT_ONE) begin
            p.trueOut = ~matchLvl;
         end
         // one-count gap, inverse clears at $00 before true sets at $01
         if (cmp == `T1PWM_CNT_ZERO) begin
            p.invOut = 1'b1;
         end else if (cmp == top) begin
            p.invOut = 1'b0;
         end else if (hit) begin
            p.invOut = 1'b1;
         end else if (newCnt && cnt == `T1PWM_CNT_ZERO) begin
            p.invOut = 1'b0;
         end
      end else begin
         p.trueEn = (mode != `T1PWM_MODE_OFF);
         p.invEn = 1'b0;
         p.invOut = 1'b0;
         if (hit || force_) begin
            case (mode)
               `T1PWM_MODE_TOGGLE: p.trueOut = ~cur.trueOut;
               `T1PWM_MODE_CLEAR: p.trueOut = 1'b0;
               `T1PWM_MODE_SET: p.trueOut = 1'b1;
               default: p.trueOut = cur.trueOut;
            endcase
         end
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic pwmA;
   logic pwmB;
   logic anyPwm;
   logic ctc;
   logic baseTick;
   logic cntTick;
   logic atTop;
   logic reachTop;
   logic [3:0] clkSel;
   logic [13:0] divMask;
   logic [7:0] flagSet;
   logic wrCtrl;
   logic wrGen;

   always_comb begin
      next_st = st;
      pwmA = st.ctrl[`T1PWM_CTRL_PWMA];
      pwmB = st.gen[`T1PWM_GEN_PWMB];
      anyPwm = pwmA || pwmB;
      ctc = st.ctrl[`T1PWM_CTRL_CTC];
      clkSel = st.ctrl[`T1PWM_CTRL_CS_HI:0];
      wrCtrl = regWr && (regAddr == `T1PWM_OFS_CTRL);
      wrGen = regWr && (regAddr == `T1PWM_OFS_GEN);
      flagSet = `T1PWM_REG_RESET;

      // fast clock tick or every system clock
      baseTick = st.fastSel ? fastClkTick : 1'b1;
      divMask = (clkSel == `T1PWM_CS_STOP) ? '0
         : `T1PWM_PRE_W'((`T1PWM_PRE_W'(1) << (clkSel - 4'h1)) - `T1PWM_PRE_W'(1));
      cntTick = baseTick && (clkSel != `T1PWM_CS_STOP) && ((st.presc & divMask) == divMask);
      if (baseTick) begin
         next_st.presc = st.presc + `T1PWM_PRE_W'(1);
      end

      // counter and top handling
      atTop = (st.cnt == st.topValue);
      reachTop = st.tickD && atTop;
      next_st.tickD = cntTick;
      next_st.evOv = 1'b0;
      if (cntTick) begin
         if ((ctc || anyPwm) && atTop) begin
            next_st.cnt = `T1PWM_CNT_ZERO;
         end else begin
            next_st.cnt = st.cnt + `T1PWM_CNT_ONE;
         end
         next_st.evOv = (st.cnt == `T1PWM_CNT_MAX) || (anyPwm && atTop);
      end

      if (reachTop) begin
         next_st.actA = st.holdA;
         next_st.actB = st.holdB;
      end

      // compare events delayed one cycle into flags
      next_st.evA = st.tickD && (st.cnt == st.actA);
      next_st.evB = st.tickD && (st.cnt == st.actB);
      flagSet[`T1PWM_FLG_A] = st.evA;
      flagSet[`T1PWM_FLG_B] = st.evB;
      flagSet[`T1PWM_FLG_OV] = st.evOv;

      next_st.pins.chanA = chanNext(pwmA, st.ctrl[`T1PWM_CTRL_MODE_HI:`T1PWM_CTRL_MODE_LO],
         st.actA, st.topValue, st.cnt, st.tickD,
         wrGen && regWrData[`T1PWM_GEN_FORCEA], st.pins.chanA);
      next_st.pins.chanB = chanNext(pwmB, st.gen[`T1PWM_GEN_MODE_HI:`T1PWM_GEN_MODE_LO],
         st.actB, st.topValue, st.cnt, st.tickD,
         wrGen && regWrData[`T1PWM_GEN_FORCEB], st.pins.chanB);

      // register writes
      if (regWr) begin
         if (regAddr == `T1PWM_OFS_CTRL) begin
            next_st.ctrl = regWrData;
         end else if (regAddr == `T1PWM_OFS_GEN) begin
            // force and prescaler reset bits are strobes, not stored
            next_st.gen = regWrData & 8'h70;
            if (regWrData[`T1PWM_GEN_PSR]) begin
               next_st.presc = '0;
            end
         end else if (regAddr == `T1PWM_OFS_CNT) begin
            next_st.cnt = regWrData;
            next_st.tickD = 1'b0;
         end else if (regAddr == `T1PWM_OFS_CMPA) begin
            next_st.holdA = regWrData;
            if (!pwmA) begin
               next_st.actA = regWrData;
            end
         end else if (regAddr == `T1PWM_OFS_CMPB) begin
            next_st.holdB = regWrData;
            if (!pwmB) begin
               next_st.actB = regWrData;
            end
         end else if (regAddr == `T1PWM_OFS_TOP) begin
            next_st.topValue = regWrData;
         end else if (regAddr == `T1PWM_OFS_PLL) begin
            next_st.fastSel = regWrData[`T1PWM_PLL_FASTSEL];
         end else if (regAddr == `T1PWM_OFS_IEN) begin
            next_st.irqEn = regWrData & 8'h64;
         end
      end

      // flags: write one clears, a new event in the same cycle wins
      next_st.flags = st.flags | flagSet;
      if (regWr && regAddr == `T1PWM_OFS_FLAG) begin
         next_st.flags = (st.flags & ~regWrData) | flagSet;
      end

      // request when flag, enable and global enable
      next_st.irq.matchA = globalIntEn && st.flags[`T1PWM_FLG_A] && st.irqEn[`T1PWM_FLG_A];
      next_st.irq.matchB = globalIntEn && st.flags[`T1PWM_FLG_B] && st.irqEn[`T1PWM_FLG_B];
      next_st.irq.overflow = globalIntEn && st.flags[`T1PWM_FLG_OV]
         && st.irqEn[`T1PWM_FLG_OV];

      // reads answer one cycle later, unmapped reads give zero
      next_st.rdData = `T1PWM_REG_RESET;
      if (regRd) begin
         if (regAddr == `T1PWM_OFS_CTRL) begin
            next_st.rdData = st.ctrl;
         end else if (regAddr == `T1PWM_OFS_GEN) begin
            next_st.rdData = st.gen;
         end else if (regAddr == `T1PWM_OFS_CNT) begin
            next_st.rdData = st.cnt;
         end else if (regAddr == `T1PWM_OFS_CMPA) begin
            next_st.rdData = st.holdA;
         end else if (regAddr == `T1PWM_OFS_CMPB) begin
            next_st.rdData = st.holdB;
         end else if (regAddr == `T1PWM_OFS_TOP) begin
            next_st.rdData = st.topValue;
         end else if (regAddr == `T1PWM_OFS_PLL) begin
            next_st.rdData[`T1PWM_PLL_FASTSEL] = st.fastSel;
            next_st.rdData[`T1PWM_PLL_LOCK] = pllLock;
         end else if (regAddr == `T1PWM_OFS_IEN) begin
            next_st.rdData = st.irqEn;
         end else if (regAddr == `T1PWM_OFS_FLAG) begin
            next_st.rdData = st.flags;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
         st.topValue <= `T1PWM_TOP_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign pins = st.pins;
   assign irq = st.irq;

endmodule // t1pwm_core

`default_nettype wire

// ### rtl/t1pwm_cfg.svh
`ifndef T1PWM_CFG_SVH
`define T1PWM_CFG_SVH

// register byte offsets
`define T1PWM_OFS_CTRL 8'h30
`define T1PWM_OFS_CNT 8'h2F
`define T1PWM_OFS_CMPA 8'h2E
`define T1PWM_OFS_CMPB 8'h2B
`define T1PWM_OFS_TOP 8'h2D
`define T1PWM_OFS_GEN 8'h2C
`define T1PWM_OFS_PLL 8'h27
`define T1PWM_OFS_IEN 8'h39
`define T1PWM_OFS_FLAG 8'h38

// control register fields
`define T1PWM_CTRL_CTC 7
`define T1PWM_CTRL_PWMA 6
`define T1PWM_CTRL_MODE_HI 5
`define T1PWM_CTRL_MODE_LO 4
`define T1PWM_CTRL_CS_HI 3

// general register fields
`define T1PWM_GEN_PWMB 6
`define T1PWM_GEN_MODE_HI 5
`define T1PWM_GEN_MODE_LO 4
`define T1PWM_GEN_FORCEB 3
`define T1PWM_GEN_FORCEA 2
`define T1PWM_GEN_PSR 1

// pll register fields
`define T1PWM_PLL_FASTSEL 2
`define T1PWM_PLL_LOCK 0

// flag and enable positions
`define T1PWM_FLG_A 6
`define T1PWM_FLG_B 5
`define T1PWM_FLG_OV 2

// output mode codes
`define T1PWM_MODE_OFF 2'h0
`define T1PWM_MODE_TOGGLE 2'h1
`define T1PWM_MODE_CLEAR 2'h2
`define T1PWM_MODE_SET 2'h3

// counter values and widths
`define T1PWM_CNT_ZERO 8'h00
`define T1PWM_CNT_ONE 8'h01
`define T1PWM_CNT_MAX 8'hFF
`define T1PWM_TOP_RESET 8'hFF
`define T1PWM_REG_RESET 8'h00
`define T1PWM_PRE_W 14
`define T1PWM_CS_STOP 4'h0

`endif

// ### rtl/t1pwm_pkg.sv
package t1pwm_pkg;

   // one complementary output pair
   typedef struct packed {
      logic trueOut;
      logic trueEn;
      logic invOut;
      logic invEn;
   } t1pwm_pair_t;

   // both channels as one group
   typedef struct packed {
      t1pwm_pair_t chanA;
      t1pwm_pair_t chanB;
   } t1pwm_pins_t;

   // interrupt requests
   typedef struct packed {
      logic matchA;
      logic matchB;
      logic overflow;
   } t1pwm_irq_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] gen;
      logic fastSel;
      logic [7:0] cnt;
      logic [7:0] topValue;
      logic [7:0] holdA;
      logic [7:0] holdB;
      logic [7:0] actA;
      logic [7:0] actB;
      logic [13:0] presc;
      logic tickD;
      logic evOv;
      logic evA;
      logic evB;
      logic [7:0] flags;
      logic [7:0] irqEn;
      t1pwm_pins_t pins;
      t1pwm_irq_t irq;
      logic [7:0] rdData;
   } t1pwm_state_t;

endpackage

// ### sim/t1pwm_checker.sv
`timescale 1ns/10ps
`default_nettype none
module t1pwm_checker (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   // context
   input wire logic fastClkTick,
   input wire logic pllLock,
   input wire logic globalIntEn,
   // outputs
   input wire t1pwm_pkg::t1pwm_pins_t pins,
   input wire t1pwm_pkg::t1pwm_irq_t irq
);
   logic [7:0] ctrl;
   logic [7:0] ien;
   logic [7:0] cmpA;
   logic [1:0] age;
   logic calm;
   // shadows; age hides the pin lag after a mode change
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= 8'h00;
         ien <= 8'h00;
         cmpA <= 8'h00;
         age <= 2'h0;
      end else begin
         if (regWr && regAddr == 8'h30) ctrl <= regWrData;
         if (regWr && regAddr == 8'h39) ien <= regWrData;
         if (regWr && regAddr == 8'h2E) cmpA <= regWrData;
         age <= (regWr && regAddr == 8'h30) ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
      end
   end
   assign calm = age == 2'h3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////////
   a_inv_normal: assert property (calm && !ctrl[6] |-> !pins.chanA.invEn)
      else $error("inverted output driven outside pwm");
   a_pwm_off: assert property (calm && ctrl[6:4] == 3'h4 |-> !pins.chanA.trueEn && !pins.chanA.invEn)
      else $error("pwm mode 00 drives a pin");
   a_inv_unused: assert property (calm && ctrl[6] && ctrl[5] |-> !pins.chanA.invEn)
      else $error("inverted output driven in mode 1x");
   a_no_overlap: assert property (calm && ctrl[6:4] == 3'h5 && pins.chanA.invEn |-> !(pins.chanA.invOut && pins.chanA.trueOut))
      else $error("pair not complementary");
   a_irq_ovf: assert property (irq.overflow |-> $past(globalIntEn) && $past(ien[2]))
      else $error("overflow request without enables");
   a_irq_match: assert property (irq.matchA |-> $past(globalIntEn) && $past(ien[6]))
      else $error("match request without enables");
   a_cmp_read: assert property (regRd && regAddr == 8'h2E |=> regRdData == $past(cmpA))
      else $error("compare read not last write");
   a_stop_hold: assert property (calm && ctrl[3:0] == 4'h0 && !$past(regWr) |-> $stable(pins))
      else $error("pins moved while stopped");
endmodule // t1pwm_checker
bind t1pwm_core t1pwm_checker chk (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
   .regRdData, .fastClkTick, .pllLock, .globalIntEn, .pins, .irq);
`default_nettype wire

// ### sim/t1pwm_load.sv
`timescale 1ns/10ps
`default_nettype none
module t1pwm_load (
   // clock
   input wire logic clk,
   // pins from the block
   input wire t1pwm_pkg::t1pwm_pins_t pins,
   // resolved pin levels
   output var logic aLevel,
   output var logic aInvLevel
);
   initial begin
      aLevel = 1'b0;
      aInvLevel = 1'b0;
   end
   // driven pin only; a floating pin wanders
   always @(posedge clk) begin
      aLevel <= pins.chanA.trueEn ? pins.chanA.trueOut : !aLevel;
      aInvLevel <= pins.chanA.invEn ? pins.chanA.invOut : !aInvLevel;
   end
endmodule // t1pwm_load
`default_nettype wire

// ### sim/t1pwm_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module t1pwm_core_tb;
   logic clk;
   logic srst;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic [7:0] regRdData;
   logic fastClkTick;
   logic pllLock;
   logic globalIntEn;
   logic [1:0] tickCnt;
   logic [7:0] rv;
   logic [15:0] rises;
   logic [15:0] highs;
   logic [15:0] eqs;
   logic aLevel;
   logic aInvLevel;
   t1pwm_pkg::t1pwm_pins_t pins;
   t1pwm_pkg::t1pwm_irq_t irq;
   int fails;
   int total_checks;
   logic [7:0] cv [10] = '{8'h51, 8'h61, 8'h71, 8'h51, 8'h51, 8'h53, 8'h91, 8'h11, 8'hB1, 8'hA1};
   logic [7:0] av [10] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
   int wv [10] = '{64, 64, 64, 64, 64, 64, 64, 512, 64, 64};
   logic [15:0] er [10] = '{16, 16, 16, 0, 0, 4, 8, 1, 0, 0};
   logic [15:0] eh [10] = '{16, 16, 48, 0, 64, 16, 32, 256, 64, 0};
   t1pwm_core dut (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .fastClkTick, .pllLock, .globalIntEn, .pins, .irq);
   t1pwm_load load (.clk, .pins, .aLevel, .aInvLevel);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // fast clock tick every third cycle
   always @(posedge clk) begin
      if (srst) begin
         tickCnt <= 2'h0;
         fastClkTick <= 1'b0;
      end else begin
         tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
         fastClkTick <= tickCnt == 2'h2;
      end
   end
   // lock comes only after the settle time
   initial begin
      pllLock = 1'b0;
      repeat (9000) @(posedge clk);
      pllLock <= 1'b1;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rv = regRdData;
   endtask
   // window must be whole periods, so counts are phase free
   task sample(input int w);
      logic last;
      rises = 0;
      highs = 0;
      eqs = 0;
      @(negedge clk);
      last = aLevel;
      repeat (w) begin
         @(negedge clk);
         if (aLevel && !last) rises++;
         if (aLevel) highs++;
         // both high at once would be an overlap; both low is the one-count gap
         if (aLevel && aInvLevel) eqs++;
         last = aLevel;
      end
   endtask
   task results;
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      globalIntEn = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(8'h30);
      chk(rv, 8'h00);
      rd(8'h2D);
      chk(rv, 8'hFF);
      wr(8'h00, 8'h5A);
      rd(8'h00);
      chk(rv, 8'h00);
      wr(8'h2D, 8'h03);
      wr(8'h30, 8'h51);
      wr(8'h2E, 8'h02);
      rd(8'h2E);
      chk(rv, 8'h02);
      for (int i = 0; i < 10; i++) begin
         wr(8'h30, cv[i]);
         wr(8'h2E, av[i]);
         repeat (300) @(posedge clk);
         sample(wv[i]);
         chk(rises, er[i]);
         chk(highs, eh[i]);
         if (cv[i][6:4] == 3'h5) chk(eqs, 16'h0000);
      end
      rd(8'h30);
      chk(rv, 8'hA1);
      wr(8'h30, 8'h41);
      repeat (20) @(posedge clk);
      chk(pins.chanA.trueEn, 1'b0);
      wr(8'h30, 8'h01);
      repeat (20) @(posedge clk);
      chk(pins.chanA.trueEn, 1'b0);
      wr(8'h30, 8'h51);
      wr(8'h2E, 8'h02);
      repeat (10000) @(posedge clk);
      rv = 8'h00;
      for (int i = 0; i < 600 && rv[0] !== 1'b1; i++) rd(8'h27);
      wr(8'h27, 8'h04);
      repeat (300) @(posedge clk);
      sample(48);
      chk(rises, 16'h0004);
      chk(highs, 16'h000C);
      wr(8'h38, 8'hFF);
      wr(8'h39, 8'h44);
      @(posedge clk);
      globalIntEn <= 1'b1;
      repeat (30) @(posedge clk);
      rd(8'h38);
      chk(rv & 8'h44, 8'h44);
      chk(irq.overflow, 1'b1);
      chk(irq.matchA, 1'b1);
      @(posedge clk);
      globalIntEn <= 1'b0;
      repeat (3) @(posedge clk);
      chk(irq.overflow, 1'b0);
      results();
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      results();
   end
endmodule // t1pwm_core_tb
`default_nettype wire
